// file: rtl/aldp_alu.sv
/*
  combinational add and and unit with flag generation.
  assumes eight-bit operands and a carry input.
*/
module aldp_alu (
  // operands
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic cin_i,
  input wire logic and_i,
  // result
  output aldp_pkg::aldp_alu_s res_o
);
  import aldp_pkg::*;

  logic [4:0] low_sum;
  logic [3:0] high_sum;
  logic [7:0] and_val;
  logic [7:0] sum_val;

  assign low_sum = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
  assign high_sum = {1'b0, a_i[6:4]} + {1'b0, b_i[6:4]} + {3'h0, low_sum[4]};
  assign sum_val = {a_i[7] ^ b_i[7] ^ high_sum[3], high_sum[2:0], low_sum[3:0]};
  assign and_val = a_i & b_i;

  always_comb begin
    res_o = '0;
    if (and_i) begin
      res_o.result = and_val;
      res_o.flags.zero = (and_val == 8'h00);
    end else begin
      res_o.result = sum_val;
      res_o.flags.zero = (sum_val == 8'h00);
      res_o.flags.carry = (a_i[7] & b_i[7]) | (high_sum[3] & (a_i[7] ^ b_i[7]));
      res_o.flags.nibble_spill_flag = low_sum[4];
      res_o.flags.signed_range_flag = (a_i[7] == b_i[7]) && (sum_val[7] != a_i[7]);
    end
  end

endmodule : aldp_alu

// file: rtl/aldp_defs.svh
/*
  constants for the add and logic datapath: opcodes, flag bit positions,
  memory size, reset values.
  assumes inclusion by bare name from rtl/ files and from the package.
*/
`ifndef ALDP_DEFS_SVH
`define ALDP_DEFS_SVH

// ----------------------------------------
// operation codes
// ----------------------------------------
`define ALDP_OP_NOP 4'h0
`define ALDP_OP_ADC 4'h1
`define ALDP_OP_ADD_WITH_SPILL_TO_MEMORY 4'h2
`define ALDP_OP_ADD_MEM 4'h3
`define ALDP_OP_ADD_IMM 4'h4
`define ALDP_OP_SUM_TO_MEMORY 4'h5
`define ALDP_OP_AND_MEM 4'h6
`define ALDP_OP_AND_IMM 4'h7
`define ALDP_OP_MASK_TO_MEMORY 4'h8
`define ALDP_OP_W 4

// ----------------------------------------
// flag positions in the flag vector
// ----------------------------------------
`define ALDP_FLAG_CARRY 0
`define ALDP_FLAG_NIBBLE 1
`define ALDP_FLAG_ZERO 2
`define ALDP_FLAG_SIGNED 3

// ----------------------------------------
// sizes and reset values
// ----------------------------------------
`define ALDP_DATA_W 8
`define ALDP_MEM_DEPTH 96
`define ALDP_ADDR_W 7
`define ALDP_WREG_RST 8'h00
`define ALDP_FLAGS_RST 4'h0

// ----------------------------------------
// wishbone register map
// ----------------------------------------
`define ALDP_REG_CMD 4'h0
`define ALDP_REG_WREG 4'h4
`define ALDP_REG_FLAGS 4'h8
`define ALDP_REG_STAT 4'hc
`define ALDP_BUS_MEM_BASE 9'h100
`define ALDP_CMD_GO_BIT 31

`endif

// file: rtl/aldp_mem.sv
/*
  data memory for the datapath: one write port, one registered read port.
  assumes a single clock; read data appear one cycle after the address.
*/
`include "aldp_defs.svh"

module aldp_mem #(
  parameter int DEPTH = `ALDP_MEM_DEPTH,
  parameter int AW = `ALDP_ADDR_W,
  parameter int DW = `ALDP_DATA_W
) (
  // clock
  input wire logic clk_i,
  // write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  // read port
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);

  logic [DW-1:0] mem_r [DEPTH];

  // ----------------------------------------
  // write
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (we_i && (int'(waddr_i) < DEPTH)) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  // ----------------------------------------
  // registered read
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (int'(raddr_i) < DEPTH) begin
      rdata_o <= mem_r[raddr_i];
    end else begin
      rdata_o <= '0;
    end
  end

endmodule : aldp_mem

// file: rtl/aldp_pkg.sv
/*
  types for the add and logic datapath.
  assumes aldp_defs.svh is on the include path.
*/
`include "aldp_defs.svh"

package aldp_pkg;

  // ----------------------------------------
  // operation selector
  // ----------------------------------------
  typedef enum logic [3:0] {
    ALDP_NOP = `ALDP_OP_NOP,
    ALDP_ADC = `ALDP_OP_ADC,
    ALDP_ADC_MEM = `ALDP_OP_ADD_WITH_SPILL_TO_MEMORY,
    ALDP_ADD_MEM = `ALDP_OP_ADD_MEM,
    ALDP_ADD_IMM = `ALDP_OP_ADD_IMM,
    ALDP_SUM_MEM = `ALDP_OP_SUM_TO_MEMORY,
    ALDP_AND_MEM = `ALDP_OP_AND_MEM,
    ALDP_AND_IMM = `ALDP_OP_AND_IMM,
    ALDP_AND_TO_MEM = `ALDP_OP_MASK_TO_MEMORY
  } aldp_op_e;

  // ----------------------------------------
  // sequencer states, gray along the path
  // ----------------------------------------
  typedef enum logic [1:0] {
    ALDP_IDLE = 2'b00,
    ALDP_READ = 2'b01,
    ALDP_EXEC = 2'b11
  } aldp_state_e;

  // ----------------------------------------
  // flag set
  // ----------------------------------------
  typedef struct packed {
    logic signed_range_flag;
    logic zero;
    logic nibble_spill_flag;
    logic carry;
  } aldp_flags_s;

  // ----------------------------------------
  // adder answer
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] result;
    aldp_flags_s flags;
  } aldp_alu_s;

  // ----------------------------------------
  // one instruction
  // ----------------------------------------
  typedef struct packed {
    aldp_op_e op;
    logic [6:0] addr;
    logic [7:0] imm;
  } aldp_cmd_s;

endpackage : aldp_pkg

// file: rtl/aldp_top.sv
/*
  add and logic datapath with working register, flags and data memory,
  reached over classic wishbone.
  assumes a single 50 MHz clock and a synchronous active high reset.
  map: 0x0 command (write: bit31 go, [3:0] op, [14:8] addr, [23:16] imm;
  read: last accepted command), 0x4 working register, 0x8 flags, 0xc status,
  0x100 + 4*n data memory byte n.
*/
`include "aldp_defs.svh"

module aldp_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic [11:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // datapath state
  output logic [7:0] working_register_o,
  output aldp_pkg::aldp_flags_s flags_o,
  output logic busy_o
);
  import aldp_pkg::*;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic is_mem_dest(input aldp_op_e op);
    is_mem_dest = (op == ALDP_ADC_MEM) || (op == ALDP_SUM_MEM) || (op == ALDP_AND_TO_MEM);
  endfunction : is_mem_dest

  function automatic logic is_and(input aldp_op_e op);
    is_and = (op == ALDP_AND_MEM) || (op == ALDP_AND_IMM) || (op == ALDP_AND_TO_MEM);
  endfunction : is_and

  function automatic logic uses_imm(input aldp_op_e op);
    uses_imm = (op == ALDP_ADD_IMM) || (op == ALDP_AND_IMM);
  endfunction : uses_imm

  function automatic logic is_valid_op(input logic [3:0] code);
    is_valid_op = (code >= `ALDP_OP_ADC) && (code <= `ALDP_OP_MASK_TO_MEMORY);
  endfunction : is_valid_op

  function automatic logic reg_hit(input logic [11:0] a, input logic [3:0] off);
    reg_hit = (a == {8'h00, off});
  endfunction : reg_hit

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] working_register_r;
  aldp_flags_s flags_r;
  aldp_state_e state_r;
  aldp_cmd_s cmd_r;
  logic bad_cmd_r;
  logic [31:0] dat_r;
  logic ack_r;
  logic err_r;
  logic mem_we;
  logic [6:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [6:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic mem_rd_pend_r;
  aldp_alu_s alu_res;
  logic [7:0] operand_b;
  logic req;
  logic wr_cmd;
  logic in_mem;
  logic [6:0] bus_idx;
  logic go;
  logic op_ok;
  logic wr_wreg;
  logic wr_flags;
  logic wr_mem;
  logic alu_cin;
  logic busy_r;
  aldp_cmd_s cmd_nxt;
  logic [31:0] cmd_word;
  logic [31:0] stat_word;

  assign req = cyc_i && stb_i && !ack_r && !err_r;
  assign in_mem = (adr_i >= 12'(`ALDP_BUS_MEM_BASE))
                  && (adr_i < 12'(`ALDP_BUS_MEM_BASE + 4 * `ALDP_MEM_DEPTH));
  assign bus_idx = 7'((adr_i - 12'(`ALDP_BUS_MEM_BASE)) >> 2);
  assign wr_cmd = req && we_i && reg_hit(adr_i, `ALDP_REG_CMD) && sel_i[3];
  assign go = wr_cmd && dat_i[`ALDP_CMD_GO_BIT] && (state_r == ALDP_IDLE);
  assign op_ok = is_valid_op(dat_i[3:0]);

  // ----------------------------------------
  // bus write strobes
  // ----------------------------------------
  // writes land only with their ack, never while busy
  assign wr_wreg = req && we_i && reg_hit(adr_i, `ALDP_REG_WREG) && sel_i[0]
                   && (state_r == ALDP_IDLE);
  assign wr_flags = req && we_i && reg_hit(adr_i, `ALDP_REG_FLAGS) && sel_i[0]
                    && (state_r == ALDP_IDLE);
  assign wr_mem = req && we_i && in_mem && sel_i[0] && (state_r == ALDP_IDLE);

  // ----------------------------------------
  // command fields
  // ----------------------------------------
  // op, address and immediate of a go write
  always_comb begin
    cmd_nxt.op = aldp_op_e'(dat_i[3:0]);
    cmd_nxt.addr = dat_i[14:8];
    cmd_nxt.imm = dat_i[23:16];
  end

  // ----------------------------------------
  // readback words
  // ----------------------------------------
  assign cmd_word = {8'h00, cmd_r.imm, 1'b0, cmd_r.addr, 4'h0, cmd_r.op};
  assign stat_word = {30'h0000_0000, bad_cmd_r, busy_r};

  // ----------------------------------------
  // operand and alu
  // ----------------------------------------
  assign operand_b = uses_imm(cmd_r.op) ? cmd_r.imm : mem_rdata;
  assign alu_cin = ((cmd_r.op == ALDP_ADC) || (cmd_r.op == ALDP_ADC_MEM)) && flags_r.carry;

  aldp_alu u_alu (
    .a_i(working_register_r),
    .b_i(operand_b),
    .cin_i(alu_cin),
    .and_i(is_and(cmd_r.op)),
    .res_o(alu_res)
  );

  // ----------------------------------------
  // data memory
  // ----------------------------------------
  always_comb begin
    mem_we = 1'b0;
    mem_waddr = cmd_r.addr;
    mem_wdata = alu_res.result;
    mem_raddr = cmd_r.addr;
    if (state_r == ALDP_EXEC) begin
      mem_we = is_mem_dest(cmd_r.op);
    end else if (state_r == ALDP_IDLE) begin
      mem_raddr = bus_idx;
      if (wr_mem) begin
        mem_we = 1'b1;
        mem_waddr = bus_idx;
        mem_wdata = dat_i[7:0];
      end
    end
  end

  aldp_mem #(
    .DEPTH(`ALDP_MEM_DEPTH),
    .AW(`ALDP_ADDR_W),
    .DW(`ALDP_DATA_W)
  ) u_mem (
    .clk_i(clk_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ALDP_IDLE;
      cmd_r <= '0;
      bad_cmd_r <= 1'b0;
    end else begin
      case (state_r)
        ALDP_IDLE: begin
          if (go) begin
            if (op_ok) begin
              cmd_r <= cmd_nxt;
              bad_cmd_r <= 1'b0;
              state_r <= ALDP_READ;
            end else begin
              bad_cmd_r <= 1'b1;
            end
          end
        end
        ALDP_READ: state_r <= ALDP_EXEC;
        ALDP_EXEC: state_r <= ALDP_IDLE;
        default: state_r <= ALDP_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // working register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      working_register_r <= `ALDP_WREG_RST;
    end else if (state_r == ALDP_EXEC) begin
      if (!is_mem_dest(cmd_r.op)) begin
        working_register_r <= alu_res.result;
      end
    end else if (wr_wreg) begin
      working_register_r <= dat_i[7:0];
    end
  end

  // ----------------------------------------
  // flags
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_r <= `ALDP_FLAGS_RST;
    end else if (state_r == ALDP_EXEC) begin
      if (is_and(cmd_r.op)) begin
        flags_r.zero <= alu_res.flags.zero;
      end else begin
        flags_r <= alu_res.flags;
      end
    end else if (wr_flags) begin
      flags_r <= dat_i[3:0];
    end
  end

  // ----------------------------------------
  // busy flag
  // ----------------------------------------
  // high through read and execute
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
    end else if (go && op_ok) begin
      busy_r <= 1'b1;
    end else if (state_r == ALDP_EXEC) begin
      busy_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // memory read wait
  // ----------------------------------------
  // registered memory: data stand one edge after the address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_rd_pend_r <= 1'b0;
    end else begin
      mem_rd_pend_r <= !mem_rd_pend_r && req && in_mem && !we_i && (state_r == ALDP_IDLE);
    end
  end

  // ----------------------------------------
  // wishbone answer
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      dat_r <= '0;
    end else begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      if (mem_rd_pend_r) begin
        ack_r <= 1'b1;
        dat_r <= {24'h00_0000, mem_rdata};
      end else if (req && in_mem) begin
        // memory writes wait for idle
        ack_r <= we_i && (state_r == ALDP_IDLE);
      end else if (req) begin
        case (adr_i)
          12'(`ALDP_REG_CMD): begin
            ack_r <= 1'b1;
            dat_r <= cmd_word;
          end
          12'(`ALDP_REG_WREG): begin
            ack_r <= (state_r == ALDP_IDLE) || !we_i;
            dat_r <= {24'h00_0000, working_register_r};
          end
          12'(`ALDP_REG_FLAGS): begin
            ack_r <= (state_r == ALDP_IDLE) || !we_i;
            dat_r <= {28'h000_0000, flags_r};
          end
          12'(`ALDP_REG_STAT): begin
            ack_r <= 1'b1;
            dat_r <= stat_word;
          end
          default: err_r <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign ack_o = ack_r;
  assign err_o = err_r;
  assign dat_o = dat_r;
  assign working_register_o = working_register_r;
  assign flags_o = flags_r;
  assign busy_o = busy_r;

endmodule : aldp_top

// file: sim/aldp_props.sv
/*
  concurrent checks on the aldp_top ports.
  assumes binding to aldp_top, one clock, sync reset.
*/
module aldp_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic [11:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  // datapath
  input wire logic [7:0] working_register_o,
  input aldp_pkg::aldp_flags_s flags_o,
  input wire logic busy_o
);
  import aldp_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic take;
  logic go;
  logic [3:0] op;
  assign take = cyc_i && stb_i && !ack_o && !err_o;
  assign go = take && we_i && adr_i == 12'h000 && sel_i[3] && dat_i[31] && !busy_o;
  assign op = dat_i[3:0];
  sequence s_go_any;
    go && op inside {[4'h1:4'h8]};
  endsequence
  sequence s_go_wreg;
    go && op inside {4'h1, 4'h3, 4'h4, 4'h6, 4'h7};
  endsequence
  sequence s_go_and;
    go && op inside {4'h6, 4'h7, 4'h8};
  endsequence
  sequence s_go_mem;
    go && op inside {4'h2, 4'h5, 4'h8};
  endsequence
  sequence s_run;
    busy_o [*2] ##1 !busy_o;
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_err_pulse: assert property (err_o |=> !err_o && !ack_o)
    else $error("err longer than one cycle");
  a_answer_cause: assert property ((ack_o || err_o) |-> $past(cyc_i && stb_i))
    else $error("answer without request");
  a_reg_latency: assert property (take && !we_i && adr_i inside {12'h004, 12'h008}
    |=> ack_o) else $error("register read late");
  a_wreg_read: assert property (ack_o && !we_i && adr_i == 12'h004
    |-> dat_o == {24'h00_0000, $past(working_register_o)}) else $error("wreg read wrong");
  a_busy_run: assert property (s_go_any |=> s_run)
    else $error("operation length wrong");
  a_zero_flag: assert property (s_go_wreg |-> ##3
    flags_o.zero == (working_register_o == 8'h00)) else $error("zero flag wrong");
  a_and_keeps: assert property (s_go_and |-> ##3
    ((flags_o ^ $past(flags_o, 3)) & 4'hb) == 4'h0) else $error("and changed flags");
  a_mem_hold: assert property (s_go_mem |-> ##3
    working_register_o == $past(working_register_o, 3)) else $error("wreg changed");
endmodule : aldp_props

bind aldp_top aldp_props u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .sel_i,
  .adr_i, .dat_i, .dat_o, .ack_o, .err_o, .working_register_o, .flags_o, .busy_o);

// file: sim/tb.sv
/*
  self-checking bench for aldp_top over classic wishbone.
  assumes the rtl files and aldp_props.sv are compiled first.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import aldp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [3:0] sel_i = 4'h0;
  logic [11:0] adr_i = 12'h000;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack_o;
  logic err_o;
  logic [7:0] working_register_o;
  aldp_flags_s flags_o;
  logic busy_o;
  logic chk = 1'b0;
  int n_mismatch = 0;
  int compares = 0;
  logic [32:0] exp_q[$];
  logic [32:0] e_w;
  logic [31:0] rng = 32'h0000_002d;
  logic [7:0] w, m, x;
  logic [3:0] f;
  aldp_top dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .sel_i, .adr_i, .dat_i,
    .dat_o, .ack_o, .err_o, .working_register_o, .flags_o, .busy_o);
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : rnd
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic ck);
    int i;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= wr;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    chk <= ck;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_i);
      if (ack_o === 1'b1 || err_o === 1'b1) break;
    end
    if (i == 50) begin
      n_mismatch++;
      wrap_up();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    chk <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 1'b0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000, 1'b1);
  endtask : rd
  task automatic run_op(input logic [3:0] op, input logic [6:0] a);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] b;
    logic [7:0] r;
    logic ci;
    int i;
    b = (op == 4'h4 || op == 4'h7) ? x : m;
    ci = (op <= 4'h2) ? f[0] : 1'b0;
    s = {1'b0, w} + {1'b0, b} + {8'h00, ci};
    h = {1'b0, w[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    wr(12'h000, {1'b1, 7'h00, x, 1'b0, a, 4'h0, op});
    for (i = 0; i < 20 && busy_o !== 1'b0; i++) begin
      @(posedge clk_i);
    end
    if (busy_o !== 1'b0) begin
      n_mismatch++;
      wrap_up();
    end
    if (op >= 4'h6) begin
      r = w & b;
      f = {f[3], r == 8'h00, f[1:0]};
    end else begin
      r = s[7:0];
      f = {w[7] == b[7] && r[7] != w[7], r == 8'h00, h[4], s[8]};
    end
    if (op inside {4'h2, 4'h5, 4'h8}) m = r;
    else w = r;
    rd(12'h000, {1'b0, 8'h00, x, 1'b0, a, 4'h0, op});
    rd(12'h004, {25'h0, w});
    rd(12'h008, {29'h0, f});
    rd(12'h100 + {3'h0, a, 2'h0}, {25'h0, m});
  endtask : run_op
  // ----------------------------------------
  // answer monitor
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (chk && (ack_o === 1'b1 || err_o === 1'b1)) begin
      e_w = exp_q.pop_front();
      check(err_o === 1'b1 ? {1'b1, 32'h0000_0000} : {1'b0, dat_o}, e_w);
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [6:0] a;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(12'h004, 33'h0);
    rd(12'h008, 33'h0);
    rd(12'h00c, 33'h0);
    $display("test reset done");
    rd(12'h010, {1'b1, 32'h0000_0000});
    wr(12'h000, 32'h8000_0000);
    rd(12'h00c, 33'h2);
    $display("test refusal done");
    for (int i = 0; i < 48; i++) begin
      if (i < 8) {w, m, x} = 24'h80_8080;
      else if (i < 16) {w, m, x} = 24'h0f_f1f1;
      else {w, m, x} = 24'(rnd());
      f = 4'(rnd());
      a = 7'(rnd() % 96);
      wr(12'h004, {24'h00_0000, w});
      wr(12'h008, {28'h000_0000, f});
      wr(12'h100 + {3'h0, a, 2'h0}, {24'h00_0000, m});
      run_op(4'(i % 8 + 1), a);
    end
    rd(12'h00c, 33'h0);
    $display("test operations done");
    wrap_up();
  end
endmodule : tb
